// file: design/darc_pkg.sv
// Shared constants and types for the DRAM area and refresh block
package darc_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_ABW   = 8'h00;
  localparam logic [7:0] OFS_AST   = 8'h04;
  localparam logic [7:0] OFS_WCH   = 8'h08;
  localparam logic [7:0] OFS_WCL   = 8'h0c;
  localparam logic [7:0] OFS_BCH   = 8'h10;
  localparam logic [7:0] OFS_BCL   = 8'h14;
  localparam logic [7:0] OFS_MEM   = 8'h18;
  localparam logic [7:0] OFS_DRC   = 8'h1c;
  localparam logic [7:0] OFS_RIC   = 8'h20;
  localparam logic [7:0] OFS_CNT   = 8'h24;
  localparam logic [7:0] OFS_IST   = 8'h28;
  localparam logic [7:0] OFS_IMK   = 8'h2c;

  // Reset values and an example time constant
  localparam logic [7:0] RST_ABW   = 8'h00;
  localparam logic [7:0] RST_AST   = 8'hff;
  localparam logic [7:0] RST_WC    = 8'hff;
  localparam logic [7:0] RST_BCH   = 8'h00;
  localparam logic [7:0] RST_BCL   = 8'h00;
  localparam logic [7:0] RST_MEM   = 8'h00;
  localparam logic [7:0] RST_DRC   = 8'h00;
  localparam logic [7:0] RST_RIC   = 8'hff;
  localparam logic [7:0] RIC_EXAMPLE = 8'h4f;

  // Field positions
  localparam int BCL_ASS   = 2;
  localparam int DRC_REFRESH_ENABLE_BIT = 7;
  localparam int DRC_RCW   = 6;
  localparam int DRC_REFRESH_MODE_SELECT = 5;
  localparam int DRC_CMF   = 4;
  localparam int DRC_COMPARE_MATCH_IRQ_ENABLE  = 3;
  localparam int IST_CMF   = 0;
  localparam int IST_SELF  = 1;

  // Encodings and the DRAM area
  localparam logic [2:0]  RMTS_A23   = 3'b011;
  localparam logic [2:0]  RMTS_A2    = 3'b001;
  localparam logic [2:0]  DRAM_AREA  = 3'd3;
  localparam logic [2:0]  CKS_DIV2   = 3'b001;
  localparam logic [23:0] DRAM_LO    = 24'h600000;
  localparam logic [23:0] DRAM_HI    = 24'h67ffff;
  localparam int          PRE_W      = 12;

  // Memory control layout
  typedef struct packed {
    logic       precharge_cycle_count;
    logic       be;
    logic       row_strobe_down_mode;
    logic       cw2;
    logic [1:0] mxc;
    logic [1:0] rlw;
  } darc_mem_t;

  // Decoded access attributes
  typedef struct packed {
    logic       dram;
    logic       narrow;
    logic       slow;
    logic [1:0] waits;
    logic [2:0] area;
  } darc_acc_t;

endpackage

// file: design/darc_top.sv
// DRAM area decode, bus configuration and refresh timer with Avalon slave
// Contract
// - In 8-bit bus mode the DRAM sits in area 3 via the DRAM interface.
// - Area 3 width bit set makes area 3 an 8-bit access space.
// - Area 3 wait field 01 inserts exactly one program wait state.
// - DRAM space select 011 makes areas 2 and 3 DRAM space.
// - Partition bit set divides 16 MB into 2 MB areas.
// - With 2 MB areas, 0x600000 to 0x67ffff decodes as area 3 DRAM.
// - Memory control bits give precharge, page, strobe and mux shift modes.
// - Refresh wait field 00 gives refresh cycles without wait states.
// - Refresh enable on, mode 0 CBR, interrupt enable 0 masks match.
// - Refresh wait control bit zero inserts no refresh wait states.
// - Clock select 001 clocks the refresh counter at clock divided by two.
// - Eight-bit time constant sets refresh interval in counter clocks.
// - Mode bit one plus standby entry puts the DRAM into self-refresh.
`timescale 1ns/1ps
module darc_top #(
  parameter int AW = 24
) (
  input  wire logic                clk_i,
  input  wire logic                rstn_i,
  input  wire logic [7:0]          avs_address_i,
  input  wire logic                avs_read_i,
  input  wire logic                avs_write_i,
  input  wire logic [31:0]         avs_writedata_i,
  input  wire logic [3:0]          avs_byteenable_i,
  output logic      [31:0]         avs_readdata_o,
  output logic                     avs_waitrequest_o,
  input  wire logic [AW-1:0]       cpu_addr_i,
  input  wire logic                narrow_mode_i,
  input  wire logic                standby_i,
  output darc_pkg::darc_acc_t      acc_o,
  output darc_pkg::darc_mem_t      mem_cfg_o,
  output logic      [1:0]          refresh_wait_o,
  output logic                     refresh_req_o,
  output logic                     self_refresh_o,
  output logic                     irq_o
);

  localparam int PRE_W_L = darc_pkg::PRE_W;

  logic [7:0]          abw_r;
  logic [7:0]          ast_r;
  logic [7:0]          wch_r;
  logic [7:0]          wcl_r;
  logic [7:0]          bch_r;
  logic [7:0]          bcl_r;
  darc_pkg::darc_mem_t mem_r;
  logic [7:0]          drc_r;
  logic [7:0]          ric_r;
  logic [7:0]          cnt_r;
  logic [1:0]          ist_r;
  logic [1:0]          imk_r;
  logic [PRE_W_L-1:0]  pre_r;
  logic                ack_r;
  logic [31:0]         rdata_r;
  darc_pkg::darc_acc_t acc_r;
  darc_pkg::darc_mem_t cfg_r;
  logic [1:0]          rwait_r;
  logic                req_r;
  logic                self_r;
  logic                irq_r;
  logic                tick;
  logic                match;
  logic                wr_en;
  logic [1:0]          set_ev;
  logic [2:0]          area;
  logic [7:0]          rd_mux;

  // Divided clock tick from the prescaler
  function automatic logic div_tick(input logic [2:0] cks,
                                    input logic [PRE_W_L-1:0] pre);
    case (cks)
      3'b001:  div_tick = pre[0];
      3'b010:  div_tick = &pre[2:0];
      3'b011:  div_tick = &pre[4:0];
      3'b100:  div_tick = &pre[6:0];
      3'b101:  div_tick = &pre[8:0];
      3'b110:  div_tick = &pre[10:0];
      3'b111:  div_tick = &pre[11:0];
      default: div_tick = 1'b0;
    endcase
  endfunction

  // Area number from address and partition unit
  function automatic logic [2:0] area_of(input logic [AW-1:0] a,
                                         input logic area_partition_select);
    if (area_partition_select) begin
      area_of = a[23:21];
    end else if (a[23:20] == 4'h0) begin
      area_of = a[19:17];
    end else begin
      area_of = 3'd7;
    end
  endfunction

  // DRAM space membership of an area
  function automatic logic is_dram(input logic [2:0] ar,
                                   input logic [2:0] rmts);
    case (rmts)
      darc_pkg::RMTS_A23: is_dram = (ar == 3'd2) || (ar == 3'd3);
      darc_pkg::RMTS_A2:  is_dram = (ar == 3'd2);
      default:            is_dram = 1'b0;
    endcase
  endfunction

  assign area   = area_of(cpu_addr_i, bcl_r[darc_pkg::BCL_ASS]);
  assign tick   = div_tick(drc_r[2:0], pre_r);
  assign match  = drc_r[darc_pkg::DRC_REFRESH_ENABLE_BIT] && tick && (cnt_r == ric_r);
  assign wr_en  = avs_write_i && ack_r && avs_byteenable_i[0];
  assign set_ev = {standby_i && !self_r && drc_r[darc_pkg::DRC_REFRESH_ENABLE_BIT]
                   && drc_r[darc_pkg::DRC_REFRESH_MODE_SELECT], match};

  // Bus handshake: one wait cycle, then a single-cycle acceptance
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= (avs_read_i || avs_write_i) && !ack_r;
    end
  end

  always_comb begin
    case (avs_address_i)
      darc_pkg::OFS_ABW: rd_mux = abw_r;
      darc_pkg::OFS_AST: rd_mux = ast_r;
      darc_pkg::OFS_WCH: rd_mux = wch_r;
      darc_pkg::OFS_WCL: rd_mux = wcl_r;
      darc_pkg::OFS_BCH: rd_mux = bch_r;
      darc_pkg::OFS_BCL: rd_mux = bcl_r;
      darc_pkg::OFS_MEM: rd_mux = mem_r;
      darc_pkg::OFS_DRC: rd_mux = {drc_r[7:5], ist_r[darc_pkg::IST_CMF],
                                   drc_r[3:0]};
      darc_pkg::OFS_RIC: rd_mux = ric_r;
      darc_pkg::OFS_CNT: rd_mux = cnt_r;
      darc_pkg::OFS_IST: rd_mux = {6'h00, ist_r};
      darc_pkg::OFS_IMK: rd_mux = {6'h00, imk_r};
      default:           rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_r <= 32'h00000000;
    end else if (avs_read_i && !ack_r) begin
      rdata_r <= {24'h000000, rd_mux};
    end
  end

  // Configuration registers
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      abw_r <= darc_pkg::RST_ABW;
      ast_r <= darc_pkg::RST_AST;
      wch_r <= darc_pkg::RST_WC;
      wcl_r <= darc_pkg::RST_WC;
      bch_r <= darc_pkg::RST_BCH;
      bcl_r <= darc_pkg::RST_BCL;
      mem_r <= darc_pkg::RST_MEM;
      drc_r <= darc_pkg::RST_DRC;
      ric_r <= darc_pkg::RST_RIC;
      imk_r <= 2'b00;
    end else if (wr_en) begin
      case (avs_address_i)
        darc_pkg::OFS_ABW: abw_r <= avs_writedata_i[7:0];
        darc_pkg::OFS_AST: ast_r <= avs_writedata_i[7:0];
        darc_pkg::OFS_WCH: wch_r <= avs_writedata_i[7:0];
        darc_pkg::OFS_WCL: wcl_r <= avs_writedata_i[7:0];
        darc_pkg::OFS_BCH: bch_r <= avs_writedata_i[7:0];
        darc_pkg::OFS_BCL: bcl_r <= avs_writedata_i[7:0];
        darc_pkg::OFS_MEM: mem_r <= avs_writedata_i[7:0];
        darc_pkg::OFS_DRC: drc_r <= avs_writedata_i[7:0];
        darc_pkg::OFS_RIC: ric_r <= avs_writedata_i[7:0];
        darc_pkg::OFS_IMK: imk_r <= avs_writedata_i[1:0];
        default:           imk_r <= imk_r;
      endcase
    end
  end

  // Sticky events, set wins over a write-one clear
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ist_r <= 2'b00;
    end else begin
      if (wr_en && avs_address_i == darc_pkg::OFS_IST) begin
        ist_r <= (ist_r & ~avs_writedata_i[1:0]) | set_ev;
      end else begin
        ist_r <= ist_r | set_ev;
      end
    end
  end

  // Prescaler and refresh interval counter
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pre_r <= '0;
    end else begin
      pre_r <= pre_r + 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_r <= 8'h00;
    end else if (!drc_r[darc_pkg::DRC_REFRESH_ENABLE_BIT]) begin
      cnt_r <= 8'h00;
    end else if (match) begin
      cnt_r <= 8'h00;
    end else if (tick) begin
      cnt_r <= cnt_r + 8'h01;
    end
  end

  // Refresh request pulse in CAS-before-RAS mode only
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      req_r <= 1'b0;
    end else begin
      req_r <= match && !drc_r[darc_pkg::DRC_REFRESH_MODE_SELECT];
    end
  end

  // Self-refresh held while in standby
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      self_r <= 1'b0;
    end else begin
      self_r <= standby_i && drc_r[darc_pkg::DRC_REFRESH_ENABLE_BIT]
                && drc_r[darc_pkg::DRC_REFRESH_MODE_SELECT];
    end
  end

  // Access attribute decode
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      acc_r <= '0;
    end else begin
      acc_r.area   <= area;
      acc_r.dram   <= is_dram(area, bch_r[2:0]);
      acc_r.narrow <= abw_r[area] || narrow_mode_i;
      acc_r.slow   <= ast_r[area];
      acc_r.waits  <= area[2] ? wch_r[{area[1:0], 1'b0} +: 2]
                              : wcl_r[{area[1:0], 1'b0} +: 2];
    end
  end

  // Strobe configuration and refresh waits
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cfg_r   <= '0;
      rwait_r <= 2'b00;
    end else begin
      cfg_r   <= mem_r;
      rwait_r <= drc_r[darc_pkg::DRC_RCW] ? mem_r.rlw
                                          : 2'b00;
    end
  end

  // Interrupt, compare match also gated by its enable bit
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= (ist_r[darc_pkg::IST_CMF] && imk_r[darc_pkg::IST_CMF]
                && drc_r[darc_pkg::DRC_COMPARE_MATCH_IRQ_ENABLE])
               || (ist_r[darc_pkg::IST_SELF] && imk_r[darc_pkg::IST_SELF]);
    end
  end

  assign avs_readdata_o    = rdata_r;
  assign avs_waitrequest_o = !ack_r;
  assign acc_o             = acc_r;
  assign mem_cfg_o         = cfg_r;
  assign refresh_wait_o    = rwait_r;
  assign refresh_req_o     = req_r;
  assign self_refresh_o    = self_r;
  assign irq_o             = irq_r;

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  sequence s_match;
    match && !drc_r[darc_pkg::DRC_REFRESH_MODE_SELECT];
  endsequence

  sequence s_flag_req;
    ist_r[darc_pkg::IST_CMF] && refresh_req_o && cnt_r == 8'h00;
  endsequence

  area3_narrow_a: assert property (
    abw_r[3] && bcl_r[darc_pkg::BCL_ASS] && cpu_addr_i[23:21] == 3'd3
    |=> acc_o.narrow && acc_o.area == darc_pkg::DRAM_AREA)
    else $error("area 3 not narrow");

  area3_wait_a: assert property (
    wcl_r[7:6] == 2'b01 && bcl_r[darc_pkg::BCL_ASS]
    && cpu_addr_i[23:21] == 3'd3 |=> acc_o.waits == 2'd1)
    else $error("area 3 wait count wrong");

  dram_window_a: assert property (
    bch_r[2:0] == darc_pkg::RMTS_A23 && bcl_r[darc_pkg::BCL_ASS]
    && cpu_addr_i >= darc_pkg::DRAM_LO && cpu_addr_i <= darc_pkg::DRAM_HI
    |=> acc_o.dram)
    else $error("DRAM window not decoded");

  dram_space_a: assert property (
    bch_r[2:0] != darc_pkg::RMTS_A23 && bch_r[2:0] != darc_pkg::RMTS_A2
    |=> !acc_o.dram)
    else $error("DRAM space without select");

  refresh_nowait_a: assert property (
    !drc_r[darc_pkg::DRC_RCW] || mem_r.rlw == 2'b00
    |=> refresh_wait_o == 2'b00)
    else $error("refresh wait inserted");

  half_clock_a: assert property (
    drc_r[2:0] == darc_pkg::CKS_DIV2 && tick
    |=> !tick ##1 tick)
    else $error("divide by two broken");

  match_flag_a: assert property (
    s_match |=> s_flag_req ##1 !refresh_req_o)
    else $error("match effects missing");

  count_bound_a: assert property (
    drc_r[darc_pkg::DRC_REFRESH_ENABLE_BIT] && cnt_r <= ric_r
    && !(wr_en && avs_address_i == darc_pkg::OFS_RIC)
    |=> cnt_r <= ric_r)
    else $error("counter passed constant");

  refresh_off_a: assert property (
    !drc_r[darc_pkg::DRC_REFRESH_ENABLE_BIT] [*2] |-> !refresh_req_o)
    else $error("refresh while disabled");

  self_entry_a: assert property (
    standby_i && drc_r[darc_pkg::DRC_REFRESH_ENABLE_BIT] && drc_r[darc_pkg::DRC_REFRESH_MODE_SELECT]
    |=> self_refresh_o)
    else $error("self-refresh not entered");

endmodule

// file: sim/darc_dram_model.sv
// Refresh monitor standing in for the DRAM chip
`timescale 1ns/1ps
module darc_dram_model #(
  parameter int LIMIT = 781
) (
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  input  wire logic        refresh_req_i,
  input  wire logic        self_refresh_i,
  output logic      [15:0] gap_o,
  output logic             starved_o
);
  logic [15:0] cnt_r;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_r     <= 16'h0000;
      gap_o     <= 16'h0000;
      starved_o <= 1'b0;
    end else begin
      if (refresh_req_i) begin
        gap_o <= cnt_r + 16'h0001;
        cnt_r <= 16'h0000;
      end else if (self_refresh_i) begin
        cnt_r <= 16'h0000;
      end else begin
        cnt_r <= cnt_r + 16'h0001;
      end
      if (int'(cnt_r) > LIMIT) begin
        starved_o <= 1'b1;
      end
    end
  end
endmodule

// file: sim/tb.sv
// Self-checking bench for the DRAM area and refresh block
`timescale 1ns/1ps
module tb;
  logic                clk_i;
  logic                rstn_i;
  logic [7:0]          bus_addr;
  logic                bus_rd;
  logic                bus_wr;
  logic [31:0]         bus_wd;
  logic [3:0]          bus_be;
  logic [31:0]         bus_rdat;
  logic                bus_wait;
  logic [23:0]         cpu_addr;
  logic                narrow;
  logic                stby;
  darc_pkg::darc_acc_t acc;
  darc_pkg::darc_mem_t mem;
  logic [1:0]          rwait;
  logic                rreq;
  logic                sref;
  logic                irq;
  logic [15:0]         gap;
  logic                starved;
  logic [7:0]          q;
  int                  miscompares;
  int                  checks;
  int                  lat;

  darc_top dut (
    .clk_i(clk_i), .rstn_i(rstn_i), .avs_address_i(bus_addr),
    .avs_read_i(bus_rd), .avs_write_i(bus_wr), .avs_writedata_i(bus_wd),
    .avs_byteenable_i(bus_be), .avs_readdata_o(bus_rdat),
    .avs_waitrequest_o(bus_wait), .cpu_addr_i(cpu_addr),
    .narrow_mode_i(narrow), .standby_i(stby), .acc_o(acc),
    .mem_cfg_o(mem), .refresh_wait_o(rwait), .refresh_req_o(rreq),
    .self_refresh_o(sref), .irq_o(irq)
  );

  darc_dram_model model (
    .clk_i(clk_i), .rstn_i(rstn_i), .refresh_req_i(rreq),
    .self_refresh_i(sref), .gap_o(gap), .starved_o(starved)
  );

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  task results;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task timeout(input string m);
    miscompares++;
    $display("MISMATCH %0t timeout in %s", $time, m);
    results();
  endtask

  task chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    bus_addr <= a;
    bus_wr   <= w;
    bus_rd   <= !w;
    bus_wd   <= {24'h000000, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (bus_wait !== 1'b0 && n < 50);
    if (bus_wait !== 1'b0) timeout("bus");
    q   = bus_rdat[7:0];
    lat = n;
    bus_rd <= 1'b0;
    bus_wr <= 1'b0;
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask

  task rd(input logic [7:0] a, input logic [7:0] e, input string m);
    bus(1'b0, a, 8'h00);
    chk({8'h00, q}, {8'h00, e}, m);
  endtask

  task settle;
    repeat (2) @(negedge clk_i);
  endtask

  task wait_req;
    int n;
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while (rreq !== 1'b1 && n < 400);
    if (rreq !== 1'b1) timeout("refresh");
  endtask

  task dec(input logic [23:0] a, input logic n, input logic [7:0] e);
    @(posedge clk_i);
    cpu_addr <= a;
    narrow   <= n;
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    chk({8'h00, acc}, {8'h00, e}, "decode");
  endtask

  task t_reset;
    rd(8'h00, darc_pkg::RST_ABW, "abw reset");
    chk(16'(lat), 16'd2, "bus latency");
    @(posedge clk_i);
    bus_be <= 4'he;
    wr(8'h00, 8'h55);
    bus_be <= 4'hf;
    rd(8'h00, darc_pkg::RST_ABW, "lane 0 off");
    rd(8'h04, darc_pkg::RST_AST, "ast reset");
    rd(8'h08, darc_pkg::RST_WC, "wch reset");
    rd(8'h10, darc_pkg::RST_BCH, "bch reset");
    rd(8'h18, darc_pkg::RST_MEM, "mem reset");
    rd(8'h24, 8'h00, "counter reset");
    rd(8'h0c, darc_pkg::RST_WC, "wcl reset");
    rd(8'h1c, darc_pkg::RST_DRC, "drc reset");
    rd(8'h20, darc_pkg::RST_RIC, "ric reset");
    rd(8'h30, 8'h00, "unmapped read");
    $display("test reset done");
  endtask

  task t_setup;
    wr(8'h00, 8'h08);
    wr(8'h0c, 8'h40);
    wr(8'h10, 8'h03);
    wr(8'h14, 8'h04);
    wr(8'h18, 8'h44);
    wr(8'h20, 8'h4f);
    wr(8'h1c, 8'h81);
    rd(8'h20, 8'h4f, "ric");
    rd(8'h1c, 8'h81, "drc");
    chk({8'h00, mem}, 16'h0044, "mem cfg");
    chk({14'h0000, rwait}, 16'h0000, "refresh wait");
    $display("test setup done");
  endtask

  task t_decode;
    dec(24'h600000, 1'b0, 8'heb);
    dec(24'h67ffff, 1'b0, 8'heb);
    dec(24'h400000, 1'b0, 8'ha2);
    dec(24'h400000, 1'b1, 8'he2);
    wr(8'h10, 8'h01);
    dec(24'h600000, 1'b0, 8'h6b);
    wr(8'h10, 8'h03);
    dec(24'he00000, 1'b0, 8'h3f);
    wr(8'h14, 8'h00);
    dec(24'h600000, 1'b0, 8'h3f);
    wr(8'h14, 8'h04);
    $display("test decode done");
  endtask

  task t_refresh;
    wait_req;
    @(negedge clk_i);
    chk({15'h0000, rreq}, 16'h0000, "pulse width");
    wait_req;
    @(negedge clk_i);
    chk(gap, 16'd160, "refresh interval");
    rd(8'h28, 8'h01, "match status");
    chk({15'h0000, irq}, 16'h0000, "irq off");
    $display("test refresh done");
  endtask

  task t_irq;
    wait_req;
    wr(8'h2c, 8'h01);
    settle;
    chk({15'h0000, irq}, 16'h0000, "irq compare_match_irq_enable off");
    wr(8'h1c, 8'h89);
    settle;
    chk({15'h0000, irq}, 16'h0001, "irq on");
    wr(8'h28, 8'h01);
    settle;
    chk({15'h0000, irq}, 16'h0000, "irq cleared");
    wait_req;
    settle;
    wr(8'h2c, 8'h00);
    settle;
    chk({15'h0000, irq}, 16'h0000, "irq masked");
    wr(8'h28, 8'h01);
    wr(8'h1c, 8'h81);
    $display("test irq done");
  endtask

  task t_self;
    int cnt;
    cnt = 0;
    wr(8'h1c, 8'ha1);
    @(posedge clk_i);
    stby <= 1'b1;
    repeat (3) @(negedge clk_i);
    chk({15'h0000, sref}, 16'h0001, "self refresh");
    bus(1'b0, 8'h28, 8'h00);
    chk({8'h00, q & 8'h02}, 16'h0002, "entry status");
    repeat (300) begin
      @(negedge clk_i);
      if (rreq !== 1'b0) cnt++;
    end
    chk(16'(cnt), 16'h0000, "no cbr in self");
    @(posedge clk_i);
    stby <= 1'b0;
    wr(8'h1c, 8'h81);
    settle;
    chk({15'h0000, sref}, 16'h0000, "self exit");
    $display("test self done");
  endtask

  task t_rwait;
    wr(8'h18, 8'h46);
    wr(8'h1c, 8'hc1);
    settle;
    chk({14'h0000, rwait}, 16'h0002, "wait on");
    chk({8'h00, mem}, 16'h0046, "mem cfg");
    wr(8'h1c, 8'h81);
    settle;
    chk({14'h0000, rwait}, 16'h0000, "wait off");
    $display("test rwait done");
  endtask

  initial begin
    miscompares = 0;
    checks      = 0;
    rstn_i      = 1'b0;
    bus_addr    = 8'h00;
    bus_rd      = 1'b0;
    bus_wr      = 1'b0;
    bus_wd      = 32'h00000000;
    bus_be      = 4'hf;
    cpu_addr    = 24'h000000;
    narrow      = 1'b0;
    stby        = 1'b0;
    repeat (16) @(posedge clk_i);
    rstn_i <= 1'b1;
    t_reset;
    t_setup;
    t_decode;
    t_refresh;
    t_irq;
    t_self;
    t_rwait;
    chk({15'h0000, starved}, 16'h0000, "dram starved");
    results();
  end
endmodule
